// *** sim/tb_tsp_timer.sv ***
// Self-checking testbench of the timer with shared prescaler
`timescale 1ns/1ps
module tb_tsp_timer;
	logic clk = 0, rstn = 0, cfg_wr = 0, wclr = 0, wtick = 0, src_en = 0, ext, rvalid, wto, wclr_o;
	logic [1:0] ph = 2'h0;
	logic [5:0] cfg_d = 6'h00;
	logic [7:0] rdata, a, d, wcnt;
	tsp_pkg::tsp_req_t req = '0;
	int err_total = 0, cmp_count = 0, n;
	tsp_timer uut (.i_core_clk(clk), .i_resetn(rstn), .i_phase(ph), .i_req(req), .i_cfg_wr(cfg_wr),
		.i_cfg_wdata(cfg_d), .i_watchdog_clear_instr(wclr), .i_watchdog_tick(wtick),
		.i_ext_count_input(ext), .o_rdata(rdata), .o_rdata_valid(rvalid),
		.o_watchdog_timeout_tick(wto), .o_watchdog_clear(wclr_o));
	tsp_ext_src src (.i_core_clk(clk), .i_en(src_en), .o_level(ext));
	initial forever #2 clk = ~clk;
	always @(negedge clk) ph <= ph + 2'h1;
	always @(posedge clk) begin
		if (wclr_o === 1'b1) wcnt <= 8'h00;
		else if (wto === 1'b1) wcnt <= wcnt + 8'h01;
	end
	task automatic wdclr();
		wclr = 1'b1;
		@(negedge clk);
		wclr = 1'b0;
		@(negedge clk);
	endtask
	function automatic logic [7:0] incs(input int cyc, input int div);
		return 8'(cyc / (4 * div));
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		req = '{1'b1, 1'b0, ad, dt};
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] q);
		req = '{1'b0, 1'b1, ad, 8'h00};
		@(negedge clk);
		chk({7'h00, rvalid}, 8'h01);
		q = rdata;
		req.rd = 1'b0;
		@(negedge clk);
	endtask
	task automatic cfg(input logic [5:0] v);
		cfg_d = v;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic span(input int cyc, input logic [7:0] exp);
		rd(8'h01, a);
		repeat (cyc - 2) @(negedge clk);
		rd(8'h01, d);
		chk(d - a, exp);
	endtask
	// One source toggle, then time for synchronisation before the read
	task automatic pulse(output logic [7:0] q);
		src_en = 1'b1;
		repeat (8) @(negedge clk);
		src_en = 1'b0;
		repeat (20) @(negedge clk);
		rd(8'h01, q);
	endtask
	initial begin
		void'($urandom(71));
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		rd(8'h01, a);
		chk(a, tsp_pkg::COUNT_RESET);
		n = $urandom_range(255, 2);
		wr(n[7:0], 8'h5a);
		rd(n[7:0], a);
		chk(a, 8'h00);
		$display("test reset and unmapped done");
		cfg(6'h08);
		span(32, incs(32, 1));
		do @(negedge clk); while (ph != 2'h3);
		d = 8'($urandom);
		wr(8'h01, d);
		repeat (15) @(negedge clk);
		rd(8'h01, a);
		chk(a, d + 8'h02);
		wdclr();
		for (n = 0; n < 8; n++) begin
			cfg({3'b000, n[2:0]});
			span(32 << (n + 1), incs(32 << (n + 1), 2 << n));
		end
		$display("test timer mode done");
		wdclr();
		for (n = 0; n < 2; n++) begin
			cfg({1'b1, n[0], 4'h8});
			wr(8'h01, 8'h00);
			repeat (12) @(negedge clk);
			pulse(a);
			chk(a, {7'h00, ~n[0]});
			pulse(a);
			chk(a, 8'h01);
		end
		wdclr();
		cfg(6'h20);
		wr(8'h01, 8'h00);
		repeat (12) @(negedge clk);
		repeat (4) pulse(a);
		chk(a, 8'h01);
		$display("test counter mode done");
		wdclr();
		wr(8'h01, 8'h00);
		for (n = 0; n < 3; n++) begin
			cfg({3'b001, n[2:0]});
			wclr = 1'b1;
			@(negedge clk);
			chk({7'h00, wclr_o}, 8'h01);
			wclr = 1'b0;
			repeat (4 << n) begin
				wtick = 1'b1;
				@(negedge clk);
				wtick = 1'b0;
				repeat (3) @(negedge clk);
			end
			repeat (4) @(negedge clk);
			chk(wcnt, incs(16 << n, 1 << n));
		end
		$display("test watchdog postscaler done");
		end_sim();
	end
	initial begin
		#120000;
		err_total++;
		end_sim();
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
endmodule // tb_tsp_timer

// *** sim/tsp_ext_src.sv ***
// Model of the external clock source that drives the count input pin
`timescale 1ns/1ps
module tsp_ext_src #(parameter int HALF = 8) (
	input wire logic i_core_clk,
	input wire logic i_en,
	output logic o_level
);
	int cnt = 0;
	initial o_level = 1'b0;
	// Each level stands HALF cycles, well past the minimum high, low and period times
	always @(posedge i_core_clk) begin
		if (i_en) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) o_level <= ~o_level;
		end
	end
endmodule // tsp_ext_src

// *** verilog/tsp_pkg.sv ***
// Package holding constants and types of the timer with shared prescaler
package tsp_pkg;
	localparam logic [7:0] TIMER_COUNT_ADDR = 8'h01;
	localparam int CFG_WIDTH = 6;
	localparam logic [5:0] CFG_RESET = 6'h3f;
	localparam int CFG_CS_BIT = 5;
	localparam int CFG_SE_BIT = 4;
	localparam int CFG_PSA_BIT = 3;
	localparam logic [7:0] PRESCALE_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
	localparam logic [1:0] PHASE_TWO = 2'h1;
	localparam logic [1:0] PHASE_FOUR = 2'h3;
	localparam int EXT_HIGH_MIN_NS = 20;
	localparam int EXT_PRESCALED_MIN_NS = 40;
	localparam int EXT_PULSE_MIN_NS = 10;

	typedef struct packed {
		logic clock_source_select;
		logic source_edge_select;
		logic scaler_assign;
		logic [2:0] scaler_ratio;
	} tsp_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tsp_req_t;
endpackage

// *** verilog/tsp_timer.sv ***
// Timer/counter with a prescaler shared with the watchdog
// Behaviour
// R1: Eight-bit count register, readable and writable
// R2: Select low: count each instruction cycle
// R3: Write inhibits counting for two cycles
// R4: Select high: count external input edges
// R5: Edge select: zero rising, one falling
// R6: Prescaler to timer or watchdog, never both
// R7: Timer ratios from 1:2 up to 1:256
// R8: Timer divides 2^(n+1), watchdog 2^n
// R9: Prescaler is one eight-bit counter
// R10: Prescaler count hidden from the processor
// R11: Count write clears prescaler when timer-assigned
// R12: Watchdog clear clears prescaler when watchdog-assigned
// R13: Reset forces prescaler to zero
// R14: Source sampled on phases two and four
// R15: External input divided before synchronisation
// R16: Source holds unscaled input high/low long enough
// R17: Source meets prescaled period and pulse width
// R18: Count increments after synchronised edge
// R19: Program follows sequence moving prescaler to watchdog
// R20: Program clears watchdog before moving prescaler back
`timescale 1ns/1ps
module tsp_timer (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [1:0] i_phase,
	input wire tsp_pkg::tsp_req_t i_req,
	input wire logic i_cfg_wr,
	input wire logic [5:0] i_cfg_wdata,
	input wire logic i_watchdog_clear_instr,
	input wire logic i_watchdog_tick,
	input wire logic i_ext_count_input,
	output logic [7:0] o_rdata,
	output logic o_rdata_valid,
	output logic o_watchdog_timeout_tick,
	output logic o_watchdog_clear
);
	tsp_pkg::tsp_cfg_t cfg, next_cfg;
	logic [7:0] timer_count_reg, next_timer_count_reg;
	logic [7:0] prescale, next_prescale;
	logic [1:0] inhibit, next_inhibit;
	logic ext_prev, next_ext_prev;
	logic sync_q, next_sync_q;
	logic sync_prev, next_sync_prev;
	logic [7:0] rdata, next_rdata;
	logic rvalid, next_rvalid;
	logic wdt_tick_out, next_wdt_tick_out;

	logic count_wr;
	logic ext_edge;
	logic timer_scaled;
	logic cycle_tick;
	logic scaler_clk;
	logic [7:0] prescale_inc;
	logic scaled_bit;
	logic src_level;
	logic sample;
	logic sync_rise;
	logic timer_inc;
	logic prescale_clear;

	assign count_wr = i_req.wr && (i_req.addr == tsp_pkg::TIMER_COUNT_ADDR); // [R1]
	assign timer_scaled = !cfg.scaler_assign; // [R6]
	assign cycle_tick = (i_phase == tsp_pkg::PHASE_FOUR);
	// Active edge of the external pin: rising or falling per edge select
	assign ext_edge = cfg.source_edge_select ? (ext_prev && !i_ext_count_input) :
		(!ext_prev && i_ext_count_input); // [R5]
	// Event that clocks the shared counter
	assign scaler_clk = timer_scaled ? (cfg.clock_source_select ? ext_edge : cycle_tick) :
		i_watchdog_tick; // [R2] [R4] [R9]
	assign prescale_inc = prescale + 8'h01;
	// Timer tap: bit n gives 2^(n+1); watchdog tap: 2^n via the previous bit
	assign scaled_bit = prescale[cfg.scaler_ratio]; // [R7] [R8]
	// Divided output is a symmetric square wave; unscaled uses the raw pin,
	// inverted for falling-edge select so the counting edge always rises
	assign src_level = cfg.clock_source_select ?
		(timer_scaled ? scaled_bit : (i_ext_count_input ^ cfg.source_edge_select)) : 1'b0; // [R15] [R5]
	assign sample = (i_phase == tsp_pkg::PHASE_TWO) || (i_phase == tsp_pkg::PHASE_FOUR); // [R14]
	// Qualified by the sample strobe so that one rise counts exactly once
	assign sync_rise = sample && sync_q && !sync_prev; // [R18]
	assign prescale_clear = (count_wr && timer_scaled) ||
		(i_watchdog_clear_instr && cfg.scaler_assign); // [R11] [R12]

	always_comb begin
		timer_inc = 1'b0;
		if (cfg.clock_source_select) begin
			timer_inc = sync_rise; // [R18]
		end else if (timer_scaled) begin
			timer_inc = cycle_tick && (prescale_inc[cfg.scaler_ratio] && !prescale[cfg.scaler_ratio]);
		end else begin
			timer_inc = cycle_tick; // [R2]
		end
	end

	// Configuration written by the option instruction
	always_comb begin
		next_cfg = cfg;
		if (i_cfg_wr) begin
			next_cfg = tsp_pkg::tsp_cfg_t'(i_cfg_wdata);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			cfg <= tsp_pkg::tsp_cfg_t'(tsp_pkg::CFG_RESET);
		end else begin
			cfg <= next_cfg;
		end
	end

	// Shared prescaler: its owner's clear wins over its owner's count event
	always_comb begin
		next_prescale = prescale;
		if (prescale_clear) begin
			next_prescale = tsp_pkg::PRESCALE_RESET; // [R11] [R12]
		end else if (scaler_clk) begin
			next_prescale = prescale_inc; // [R9]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			prescale <= tsp_pkg::PRESCALE_RESET; // [R13]
		end else begin
			prescale <= next_prescale;
		end
	end

	// Pin history for edge detection and the phase sampler of the count source
	always_comb begin
		next_ext_prev = i_ext_count_input;
		next_sync_q = sync_q;
		next_sync_prev = sync_prev;
		if (sample) begin
			next_sync_q = src_level; // [R14]
			next_sync_prev = sync_q;
		end
	end

	// Sampler starts high so that no rise is seen straight after reset
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			ext_prev <= 1'b0;
			sync_q <= 1'b1;
			sync_prev <= 1'b1;
		end else begin
			ext_prev <= next_ext_prev;
			sync_q <= next_sync_q;
			sync_prev <= next_sync_prev;
		end
	end

	// Count register and the post-write inhibit; a write wins over an increment
	always_comb begin
		next_timer_count_reg = timer_count_reg;
		next_inhibit = inhibit;
		if (count_wr) begin
			next_timer_count_reg = i_req.wdata; // [R1]
			next_inhibit = tsp_pkg::INHIBIT_CYCLES; // [R3]
		end else begin
			if (timer_inc && inhibit == 2'h0) begin
				next_timer_count_reg = timer_count_reg + 8'h01;
			end
			if (cycle_tick && inhibit != 2'h0) begin
				next_inhibit = inhibit - 2'h1; // [R3]
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			timer_count_reg <= tsp_pkg::COUNT_RESET;
			inhibit <= 2'h0;
		end else begin
			timer_count_reg <= next_timer_count_reg;
			inhibit <= next_inhibit;
		end
	end

	// Only the count register is readable; the prescaler never is
	always_comb begin
		next_rdata = rdata;
		next_rvalid = 1'b0;
		if (i_req.rd) begin
			next_rvalid = 1'b1;
			next_rdata = (i_req.addr == tsp_pkg::TIMER_COUNT_ADDR) ? timer_count_reg : 8'h00; // [R10]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// Watchdog postscaler output: ratio 0 passes ticks, ratio n taps bit n-1
	always_comb begin
		next_wdt_tick_out = i_watchdog_tick; // [R6]
		if (cfg.scaler_assign && cfg.scaler_ratio != 3'h0) begin
			next_wdt_tick_out = i_watchdog_tick && prescale_inc[cfg.scaler_ratio - 3'h1] &&
				!prescale[cfg.scaler_ratio - 3'h1]; // [R8]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			wdt_tick_out <= 1'b0;
		end else begin
			wdt_tick_out <= next_wdt_tick_out;
		end
	end

	assign o_rdata = rdata;
	assign o_rdata_valid = rvalid;
	assign o_watchdog_timeout_tick = wdt_tick_out;
	assign o_watchdog_clear = i_watchdog_clear_instr;

	a_write_loads_count: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		count_wr |=> timer_count_reg == $past(i_req.wdata)) else $error("count write not loaded"); // [R1]
	a_inhibit_after_write: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R3]
		count_wr ##1 !count_wr |=> timer_count_reg == $past(timer_count_reg)) else $error("count moved after write");
	a_timer_clear_scaler: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		count_wr && !cfg.scaler_assign |=> prescale == 8'h00) else $error("prescaler not cleared"); // [R11]
	a_wdt_clear_scaler: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		i_watchdog_clear_instr && cfg.scaler_assign |=> prescale == 8'h00) else $error("prescaler kept on clear"); // [R12]
	a_reset_scaler_zero: assert property (@(posedge i_core_clk)
		!i_resetn |=> prescale == 8'h00) else $error("prescaler not zero after reset"); // [R13]
	a_sync_only_phases: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!sample |=> sync_q == $past(sync_q)) else $error("sync sampled off phase"); // [R14]
	a_count_step_one: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!$past(count_wr) && timer_count_reg != $past(timer_count_reg) |->
		timer_count_reg == $past(timer_count_reg) + 8'h01)
		else $error("count jumped"); // [R2]
	a_ext_needs_sync: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		cfg.clock_source_select && !count_wr && !sync_rise |=> timer_count_reg == $past(timer_count_reg))
		else $error("external count without edge"); // [R18]
	a_read_hides_scaler: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		i_req.rd && i_req.addr != tsp_pkg::TIMER_COUNT_ADDR |=> o_rdata == 8'h00) else $error("other read nonzero"); // [R10]

	// Register bus answers, count reset and configuration load
	a_read_valid_pulse: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R1]
		i_req.rd |=> o_rdata_valid) else $error("read not answered");
	a_read_returns_count: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R1]
		i_req.rd && i_req.addr == tsp_pkg::TIMER_COUNT_ADDR |=> o_rdata == $past(timer_count_reg))
		else $error("read data not count");
	a_reset_count_zero: assert property (@(posedge i_core_clk) // [R1]
		!i_resetn |=> timer_count_reg == tsp_pkg::COUNT_RESET) else $error("count not reset");
	a_config_loads: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R4]
		i_cfg_wr |=> cfg == $past(i_cfg_wdata)) else $error("config not loaded");

	// Post-write inhibit
	a_write_sets_inhibit: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R3]
		count_wr |=> inhibit == tsp_pkg::INHIBIT_CYCLES) else $error("inhibit not armed");
	a_inhibit_holds_count: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R3]
		inhibit != 2'h0 && !count_wr |=> timer_count_reg == $past(timer_count_reg))
		else $error("count moved while inhibited");
	a_inhibit_only_decays: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R3]
		inhibit != 2'h0 && !count_wr |=> inhibit <= $past(inhibit)) else $error("inhibit grew");

	// Timer mode counting
	a_timer_mode_tick: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R2]
		!cfg.clock_source_select && cfg.scaler_assign && !count_wr && inhibit == 2'h0 && cycle_tick
		|=> timer_count_reg == $past(timer_count_reg) + 8'h01) else $error("timer tick missed");
	a_timer_mode_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R2]
		!cfg.clock_source_select && !cycle_tick && !count_wr |=> timer_count_reg == $past(timer_count_reg))
		else $error("timer moved off tick");
	a_scaled_timer_tap: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R8]
		!cfg.clock_source_select && !cfg.scaler_assign && !count_wr && inhibit == 2'h0 && cycle_tick &&
		prescale_inc[cfg.scaler_ratio] && !prescale[cfg.scaler_ratio]
		|=> timer_count_reg == $past(timer_count_reg) + 8'h01) else $error("scaled tick missed");

	// Prescaler ownership and stepping
	a_scaler_step_one: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R9]
		!prescale_clear && scaler_clk |=> prescale == $past(prescale) + 8'h01) else $error("prescaler step wrong");
	a_scaler_owner_wdt: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R6]
		cfg.scaler_assign && !i_watchdog_tick && !i_watchdog_clear_instr |=> prescale == $past(prescale))
		else $error("prescaler moved without watchdog tick");
	a_ext_edge_scaler: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R15]
		cfg.clock_source_select && !cfg.scaler_assign && ext_edge && !prescale_clear
		|=> prescale == $past(prescale) + 8'h01) else $error("pin edge not divided");
	a_wdt_unscaled: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R6]
		!cfg.scaler_assign |=> o_watchdog_timeout_tick == $past(i_watchdog_tick))
		else $error("watchdog tick not passed");
	a_wdt_tick_needed: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R8]
		!i_watchdog_tick |=> !o_watchdog_timeout_tick) else $error("watchdog tick without input");

	// External count path
	a_sync_samples_level: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R14]
		sample |=> sync_q == $past(src_level)) else $error("sampler missed level");
	a_ext_edge_inc: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R18]
		cfg.clock_source_select && sync_rise && inhibit == 2'h0 && !count_wr
		|=> timer_count_reg == $past(timer_count_reg) + 8'h01) else $error("synchronised edge not counted");
endmodule // tsp_timer
